// >>> common/bit_skip_call_pkg.sv
// Constants and types shared by the bit, skip and call execution logic.
package bit_skip_call_pkg;
    localparam int INSN_W    = 14;
    localparam int PC_W      = 13;
    localparam int LIT_W     = 11;
    localparam int FADDR_W   = 7;
    localparam int DATA_W    = 8;
    localparam int BIT_LO    = 7;
    localparam int BIT_HI    = 9;
    localparam int LATCH_LO  = 3;
    localparam int LATCH_HI  = 4;
    localparam logic [1:0] GRP_BIT  = 2'h1;
    localparam logic [1:0] GRP_JUMP = 2'h2;
    localparam logic [1:0] BIT_SET  = 2'h1;
    localparam logic [1:0] BIT_SKIP = 2'h3;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [PC_W-1:0] PC_STEP  = 13'h0001;
    localparam logic [DATA_W-1:0] ONE_HOT_BASE = 8'h01;

    typedef enum logic [1:0] {
        Q1 = 2'b00,
        Q2 = 2'b01,
        Q3 = 2'b10,
        Q4 = 2'b11
    } quarter_e;

    typedef enum logic [1:0] {
        OP_OTHER = 2'b00,
        OP_SET   = 2'b01,
        OP_SKIP  = 2'b10,
        OP_CALL  = 2'b11
    } op_e;
endpackage : bit_skip_call_pkg

// >>> common/decode_if.sv
// Decoded instruction fields passed from the decoder to the execution core.
`timescale 1ns/1ps
`default_nettype none
interface decode_if;
    import bit_skip_call_pkg::*;
    op_e                 op;
    logic [FADDR_W-1:0]  faddr;
    logic [2:0]          bsel;
    logic [LIT_W-1:0]    lit;
    modport dec (output op, faddr, bsel, lit);
    modport core (input op, faddr, bsel, lit);
endinterface : decode_if
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the bit set, skip test and call execution block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import bit_skip_call_pkg::*;
    logic               sys_clk = 1'b0;
    logic               sys_rst = 1'b1;
    logic [INSN_W-1:0]  insn = '0;
    logic [DATA_W-1:0]  high_address_latch = '0;
    logic [DATA_W-1:0]  file_rdata;
    logic               file_rd, file_wr, push, insn_take, nop_cycle;
    logic [FADDR_W-1:0] file_addr;
    logic [DATA_W-1:0]  file_wdata;
    logic [PC_W-1:0]    pc, return_stack_top, p0;
    quarter_e           quarter;
    logic [DATA_W-1:0]  file_mem [128];
    int                 num_errors = 0;
    int                 total_checks = 0;

    // The bench plays the file register array.
    assign file_rdata = file_mem[file_addr];

    bit_skip_and_call_execute dut (
        .sys_clk, .sys_rst, .insn, .high_address_latch, .file_rdata, .file_rd,
        .file_wr, .file_addr, .file_wdata, .pc, .push, .return_stack_top,
        .quarter, .insn_take, .nop_cycle
    );

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    // Presents one word for the next Q1 edge and returns in the middle of Q2.
    task automatic issue(input logic [INSN_W-1:0] w, input logic rd, input logic psh);
        @(posedge sys_clk iff quarter == Q4);
        insn <= w;
        @(negedge sys_clk);
        p0 = pc;
        @(posedge sys_clk);
        insn <= '0;
        @(negedge sys_clk);
        check("quarter", Q2, quarter);
        check("insn_take", 1'b1, insn_take);
        check("file_rd", rd, file_rd);
        check("push", psh, push);
    endtask : issue

    task automatic t_set();
        for (int b = 0; b < 8; b++) begin
            file_mem[7'h2A] = 8'h0A;
            issue({4'b0101, b[2:0], 7'h2A}, 1'b1, 1'b0);
            check("file_addr", 16'h002A, file_addr);
            check("file_wr_q2", 1'b0, file_wr);
            repeat (2) @(negedge sys_clk);
            check("file_wr", 1'b1, file_wr);
            check("file_wdata", 8'h0A | (8'h01 << b), file_wdata);
            @(negedge sys_clk);
            check("pc_set", p0 + 13'h0001, pc);
        end
        $display("TEST bit set done");
    endtask : t_set

    task automatic t_skip();
        file_mem[7'h11] = 8'h80;
        issue({4'b0111, 3'd0, 7'h11}, 1'b1, 1'b0);
        repeat (3) @(negedge sys_clk);
        check("nop_miss", 1'b0, nop_cycle);
        check("pc_miss", p0 + 13'h0001, pc);
        issue({4'b0111, 3'd7, 7'h11}, 1'b1, 1'b0);
        repeat (2) @(negedge sys_clk);
        check("file_wr_skip", 1'b0, file_wr);
        @(negedge sys_clk);
        check("nop_hit", 1'b1, nop_cycle);
        @(negedge sys_clk);
        check("take_nop", 1'b0, insn_take);
        repeat (3) @(negedge sys_clk);
        check("pc_hit", p0 + 13'h0002, pc);
        check("nop_end", 1'b0, nop_cycle);
        $display("TEST skip done");
    endtask : t_skip

    task automatic t_call(input logic [7:0] lat, input logic [10:0] k);
        @(posedge sys_clk);
        high_address_latch <= lat;
        issue({3'b100, k}, 1'b0, 1'b1);
        check("stack_top", p0 + 13'h0001, return_stack_top);
        repeat (3) @(negedge sys_clk);
        check("pc_call", {lat[4:3], k}, pc);
        check("nop_call", 1'b1, nop_cycle);
        @(negedge sys_clk);
        check("take_call_nop", 1'b0, insn_take);
        repeat (3) @(negedge sys_clk);
        check("nop_call_end", 1'b0, nop_cycle);
        $display("TEST call done");
    endtask : t_call

    task automatic t_other();
        issue(14'h3FFF, 1'b0, 1'b0);
        repeat (3) @(negedge sys_clk);
        check("pc_other", p0 + 13'h0001, pc);
        check("nop_other", 1'b0, nop_cycle);
        $display("TEST other opcode done");
    endtask : t_other

    task automatic report_and_stop();
        $display("TB: checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 128; i++) begin
            file_mem[i] = '0;
        end
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_set();
        t_skip();
        t_call(8'h08, 11'h7FF);
        t_call(8'hF7, 11'h000);
        t_call(8'h18, 11'h555);
        t_other();
        report_and_stop();
    end

    // Cuts a hang short well beyond the roughly 130 cycles the tests need.
    initial begin
        repeat (4000) @(posedge sys_clk);
        num_errors++;
        report_and_stop();
    end
endmodule : tb
`default_nettype wire

// >>> verilog/bit_skip_and_call_execute.sv
// Quarter-phase execution of bit set, bit test skip and subroutine call.
// What this block does
// RULE1 - A bit set decodes in Q1, reads the file in Q2, modifies in Q3 and writes back in Q4.
// RULE2 - A skip-if-set test reads file bit b and, when it is one, replaces the next word by a no-op cycle.
// RULE3 - A call pushes PC+1 onto the return stack top and loads the 11-bit literal into PC bits 10 to 0.
// RULE4 - A call fills PC bits 12 and 11 from latch bits 4 and 3 and spends a second no-op cycle.
// RULE5 - One 14-bit word is taken per instruction cycle except in a no-op cycle, and the leading opcode bits pick the behaviour.
`timescale 1ns/1ps
`default_nettype none
module bit_skip_and_call_execute
    import bit_skip_call_pkg::*;
(
    // Clock and reset.
    input  wire logic                sys_clk,
    input  wire logic                sys_rst,
    // Instruction fetch.
    input  wire logic [INSN_W-1:0]   insn,
    input  wire logic [DATA_W-1:0]   high_address_latch,
    // File register port.
    input  wire logic [DATA_W-1:0]   file_rdata,
    output logic                     file_rd,
    output logic                     file_wr,
    output logic [FADDR_W-1:0]       file_addr,
    output logic [DATA_W-1:0]        file_wdata,
    // Program counter and stack.
    output logic [PC_W-1:0]          pc,
    output logic                     push,
    output logic [PC_W-1:0]          return_stack_top,
    // Cycle state.
    output quarter_e                 quarter,
    output logic                     insn_take,
    output logic                     nop_cycle
);
    import bit_skip_call_pkg::*;

    decode_if dbus ();

    insn_decoder u_dec (
        .insn (insn),
        .dec  (dbus)
    );

    ////////////////////////////////////////////////////////////////////////////
    op_e                op;
    logic [FADDR_W-1:0] faddr;
    logic [2:0]         bsel;
    logic [LIT_W-1:0]   lit;
    logic [DATA_W-1:0]  data;
    logic               skip_hit;
    logic               next_nop;

    // Q1 latches the word only when the cycle is not a discarded one.
    wire logic          at_q1   = (quarter == Q1);
    wire logic          at_q2   = (quarter == Q2);
    wire logic          at_q3   = (quarter == Q3);
    wire logic          at_q4   = (quarter == Q4);
    wire logic          take    = at_q1 && !nop_cycle;
    wire logic          tested  = file_rdata[bsel];
    wire logic [DATA_W-1:0] set_mask = ONE_HOT_BASE << bsel;
    wire logic [PC_W-1:0]   pc_inc   = pc + PC_STEP;
    wire logic [PC_W-1:0]   call_pc  = {high_address_latch[LATCH_HI:LATCH_LO], lit};
    // The push is launched from the taking edge, so it stands in Q2 while PC still holds
    // the address of the call itself.
    wire logic          take_call = take && (dbus.op == OP_CALL);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            quarter <= Q1;
        end else begin
            quarter <= quarter_e'(quarter + 2'h1);
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            op    <= OP_OTHER;
            faddr <= '0;
            bsel  <= '0;
            lit   <= '0;
        end else if (take) begin
            op    <= dbus.op;    // [RULE5]
            faddr <= dbus.faddr;
            bsel  <= dbus.bsel;
            lit   <= dbus.lit;
        end else if (at_q1) begin
            op    <= OP_OTHER;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            insn_take <= 1'b0;
        end else begin
            insn_take <= take;   // [RULE5]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // File access: read strobe during Q2, write strobe during Q4.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            file_rd   <= 1'b0;
            file_addr <= '0;
        end else begin
            file_rd   <= take && (dbus.op == OP_SET || dbus.op == OP_SKIP); // [RULE1] [RULE2]
            file_addr <= take ? dbus.faddr : file_addr;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            data     <= '0;
            skip_hit <= 1'b0;
        end else if (at_q2 && file_rd) begin
            data     <= file_rdata;                 // [RULE1]
            skip_hit <= (op == OP_SKIP) && tested;  // [RULE2]
        end else if (at_q1) begin
            skip_hit <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            file_wr    <= 1'b0;
            file_wdata <= '0;
        end else begin
            file_wr    <= at_q3 && (op == OP_SET);                    // [RULE1]
            file_wdata <= at_q3 ? (data | set_mask) : file_wdata;     // [RULE1]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Program counter and discarded-cycle flag resolved in Q4, stack push at the taking Q1 edge.
    assign next_nop = (op == OP_CALL) || skip_hit;  // [RULE2] [RULE4]

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pc               <= PC_RESET;
            push             <= 1'b0;
            return_stack_top <= PC_RESET;
            nop_cycle        <= 1'b0;
        end else begin
            push <= take_call;                                      // [RULE3]
            if (at_q4) begin
                nop_cycle <= next_nop;
                pc        <= (op == OP_CALL) ? call_pc : pc_inc;   // [RULE3] [RULE4]
            end
            if (take_call) begin
                return_stack_top <= pc_inc;                         // [RULE3]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence set_read_s;
        file_rd && quarter == Q2 && op == OP_SET;
    endsequence

    sequence set_write_s;
        ##2 (file_wr && quarter == Q4);
    endsequence

    set_order_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE1]
        set_read_s |-> set_write_s)
        else $error("bit set did not write back in Q4");

    set_bit_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE1]
        file_wr |-> file_wdata[bsel])
        else $error("bit set wrote the bit as zero");

    write_only_q4_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE1]
        file_wr |-> quarter == Q4)
        else $error("file write outside Q4");

    skip_nop_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE2]
        (at_q4 && op == OP_SKIP && skip_hit) |=> nop_cycle [*4])
        else $error("skip did not discard next word");

    no_skip_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE2]
        (at_q4 && op == OP_SKIP && !skip_hit) |=> !nop_cycle)
        else $error("skip taken on clear bit");

    call_pc_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE3]
        (at_q4 && op == OP_CALL) |=> pc[LIT_W-1:0] == $past(lit))
        else $error("call literal not loaded");

    call_push_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE3]
        push |-> return_stack_top == pc + PC_STEP)
        else $error("pushed address is not PC plus one");

    call_high_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE4]
        (at_q4 && op == OP_CALL) |=>
            (pc[PC_W-1:LIT_W] == $past(high_address_latch[LATCH_HI:LATCH_LO])) && nop_cycle)
        else $error("call high bits or second cycle wrong");

    take_rate_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE5]
        insn_take |=> !insn_take [*3])
        else $error("more than one word per cycle");

    read_only_q2_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE1]
        file_rd |-> quarter == Q2)
        else $error("file read outside Q2");

    quarter_wrap_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE1]
        at_q4 |=> at_q1)
        else $error("quarter did not wrap to Q1");

    skip_no_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE2]
        (op == OP_SKIP) |-> !file_wr)
        else $error("skip test wrote the file");

    nop_no_take_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE2]
        (at_q1 && nop_cycle) |=> !insn_take)
        else $error("word taken in a discarded cycle");

    call_push_pulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE3]
        (insn_take && op == OP_CALL) |-> push)
        else $error("call did not push");

    push_once_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE3]
        push |=> !push)
        else $error("push held longer than one cycle");
endmodule : bit_skip_and_call_execute
`default_nettype wire

// >>> verilog/insn_decoder.sv
// Combinational field split and opcode selection of one instruction word.
`timescale 1ns/1ps
`default_nettype none
module insn_decoder
    import bit_skip_call_pkg::*;
(
    // Instruction word.
    input  wire logic [INSN_W-1:0] insn,
    // Decoded fields.
    decode_if.dec                  dec
);
    wire logic [1:0] grp  = insn[INSN_W-1:INSN_W-2];
    wire logic [1:0] sub  = insn[INSN_W-3:INSN_W-4];
    wire logic       is_set  = (grp == GRP_BIT) && (sub == BIT_SET);
    wire logic       is_skip = (grp == GRP_BIT) && (sub == BIT_SKIP);
    wire logic       is_call = (grp == GRP_JUMP) && !insn[LIT_W];

    assign dec.op    = is_call ? OP_CALL : is_skip ? OP_SKIP :
                       is_set ? OP_SET : OP_OTHER;
    assign dec.faddr = insn[FADDR_W-1:0];
    assign dec.bsel  = insn[BIT_HI:BIT_LO];
    assign dec.lit   = insn[LIT_W-1:0];
endmodule : insn_decoder
`default_nettype wire
